// *** rtl/ric_core.sv ***
// Operation
// RULE_01: Reset comes from active-low pin or power-on detector.
// RULE_02: Outside party holds reset pin low at least one and a half cycles.
// RULE_03: Power-on reset only on supply rise, none on supply drop.
// RULE_04: Crystal option: 4064 cycle delay, then wait for pin high.
// RULE_05: RC option: 2 cycle delay, then wait while pin low.
// RULE_06: Pin restart not from stop: 2 cycle start delay.
// RULE_07: Pin restart from stop clears stop latch, full 4064 cycle delay.
// RULE_08: Reset zeroes timer prescaler and loads counter with fffc.
// RULE_09: Reset clears compare pin, level bit and timer enables.
// RULE_10: Reset clears oscillator bits, directions, open drain, line enables.
// RULE_11: Reset clears line flags; low pins set them again afterwards.
// RULE_12: Reset sets stack to 0ff, fetch to ffe, global mask set.
// RULE_13: Reset clears external latch, wait latch and stop latch.
// RULE_14: Four sources: external, timer, port lines maskable; soft trap not.
// RULE_15: Cleared enable blocks request but flag still sets.
// RULE_16: Flag clears after status access then associated register access.
// RULE_17: Interrupt taken at instruction end; stack, set mask, load vector.
// RULE_18: Trap return restores stacked state and resumes.
// RULE_19: Pin low starts program from ffe vector with mask set.
// RULE_20: Stop wakes on reset, external, line, or timer with ext clock.
// RULE_21: Wait wakes on reset, external, timer or line interrupt.
// RULE_22: Exit from low power uses ordinary vectors, no indication.
// RULE_23: Soft trap runs regardless of mask, vector ffc.
// RULE_24: External pin low with mask clear is recognised, vector ffa.
// RULE_25: Three timer flags each gated, share vector ff8.
// RULE_26: Four line requests share level request, vector ff6.
// RULE_27: Priority: reset, soft trap, external, timer, port lines.
`timescale 1ns/100ps
module ric_core
    import ric_pkg::*;
(
    input  wire logic         clk_in,
    input  wire logic         rst_in,
    input  wire logic         por_in,
    input  wire logic         reset_pin_n_in,
    input  wire logic         irq_pin_n_in,
    input  wire logic         crystal_opt_in,
    input  wire logic         osc_ready_in,
    input  wire logic         insn_end_in,
    input  wire logic         soft_trap_in,
    input  wire logic         trap_return_in,
    input  wire logic         stop_in,
    input  wire logic         wait_in,
    input  wire logic         mask_clear_in,
    input  wire logic         capture_flag_in,
    input  wire logic         match_flag_in,
    input  wire logic         wrap_flag_in,
    input  wire logic         capture_int_en_in,
    input  wire logic         match_int_en_in,
    input  wire logic         wrap_int_en_in,
    input  wire logic         timer_ext_clk_on_in,
    input  wire logic [3:0]   line_pin_n_in,
    input  wire logic [3:0]   line_int_enables_in,
    input  wire logic         status_access_in,
    input  wire logic [3:0]   line_flag_clr_in,
    input  wire logic         capture_assoc_in,
    input  wire logic         match_assoc_in,
    input  wire logic         wrap_assoc_in,
    output logic              core_reset_out,
    output logic              periph_reset_out,
    output logic [15:0]       timer_preload_out,
    output logic [1:0]        prescale_preload_out,
    output logic [11:0]       stack_preload_out,
    output logic              global_mask_out,
    output logic              take_int_out,
    output ric_pkg::ric_src_t take_src_out,
    output logic [11:0]       vector_out,
    output logic              restore_out,
    output logic              osc_off_out,
    output logic              core_clk_gate_out,
    output logic [3:0]        line_int_flags_out,
    output logic              capture_clr_out,
    output logic              match_clr_out,
    output logic              wrap_clr_out
);
    import ric_pkg::*;

    localparam logic [CNT_W-1:0] LONG_LOAD  = CNT_W'(LONG_START_CYC);
    localparam logic [CNT_W-1:0] SHORT_LOAD = CNT_W'(SHORT_START_CYC);

    function automatic logic timer_req(input logic cf, ce, mf, me, wf, we);
        timer_req = (cf && ce) || (mf && me) || (wf && we);
    endfunction

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic       rpin_s1_q, rpin_s2_q, irq_s1_q, irq_s2_q, por_s1_q, por_s2_q;
    logic       osc_s1_q, osc_s2_q;
    logic [3:0] line_s1_q, line_s2_q;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            {rpin_s1_q, rpin_s2_q, irq_s1_q, irq_s2_q} <= 4'hf;
            {por_s1_q, por_s2_q, osc_s1_q, osc_s2_q}   <= 4'h0;
            line_s1_q <= 4'hf;
            line_s2_q <= 4'hf;
        end else begin
            rpin_s1_q <= reset_pin_n_in;
            rpin_s2_q <= rpin_s1_q;
            irq_s1_q  <= irq_pin_n_in;
            irq_s2_q  <= irq_s1_q;
            por_s1_q  <= por_in;
            por_s2_q  <= por_s1_q;
            osc_s1_q  <= osc_ready_in;
            osc_s2_q  <= osc_s1_q;
            line_s1_q <= line_pin_n_in;
            line_s2_q <= line_s1_q;
        end
    end

    // ****************************************
    // Reset sequencing
    // ****************************************
    logic       por_seen_q, por_pend_q, pin_prev_q, stop_q, wait_q;
    logic       load, busy;
    logic [CNT_W-1:0] load_val;
    logic       por_rise, pin_low, pin_rise;

    // RULE_03 supply rise only
    assign por_rise = por_s2_q && !por_seen_q;
    assign pin_low  = !rpin_s2_q;
    assign pin_rise = rpin_s2_q && !pin_prev_q;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            por_seen_q <= 1'b0;
            por_pend_q <= 1'b0;
            pin_prev_q <= 1'b1;
        end else begin
            por_seen_q <= por_s2_q;
            pin_prev_q <= rpin_s2_q;
            if (por_rise) begin
                por_pend_q <= 1'b1;
            end else if (por_pend_q && osc_s2_q) begin
                por_pend_q <= 1'b0;
            end
        end
    end

    always_comb begin
        load     = 1'b0;
        load_val = SHORT_LOAD;
        if (rst_in) begin
            // Start counter has no reset of its own, so preload it here
            load     = 1'b1;
            load_val = SHORT_LOAD;
        end else if (por_pend_q && osc_s2_q) begin
            // RULE_04 crystal long delay
            // RULE_05 RC short delay
            load     = 1'b1;
            load_val = crystal_opt_in ? LONG_LOAD : SHORT_LOAD;
        end else if (pin_rise) begin
            // RULE_06 short pin restart
            // RULE_07 stop exit long delay
            load     = 1'b1;
            load_val = stop_q ? LONG_LOAD : SHORT_LOAD;
        end
    end

    ric_start_timer u_start (
        .clk_in   (clk_in),
        .load_in  (load),
        .count_in (load_val),
        .busy_out (busy)
    );

    // RULE_01 merge reset sources
    // RULE_19 pin low holds reset
    assign core_reset_out = rst_in || por_rise || por_pend_q || pin_low || busy;
    // RULE_08 timer preload
    // RULE_09 timer bits cleared
    // RULE_10 config bits cleared
    assign periph_reset_out     = core_reset_out;
    assign timer_preload_out    = TIMER_PRELOAD;
    assign prescale_preload_out = PRESCALE_ZERO;
    // RULE_12 stack top
    assign stack_preload_out    = STACK_TOP;

    // ****************************************
    // Port line flags
    // ****************************************
    logic [3:0] flags_q;
    // RULE_11 flags cleared, relatch
    // RULE_16 set wins over clear
    always_ff @(posedge clk_in) begin
        if (core_reset_out) begin
            flags_q <= 4'h0;
        end else begin
            flags_q <= (flags_q & ~line_flag_clr_in) | ~line_s2_q;
        end
    end
    assign line_int_flags_out = flags_q;

    // ****************************************
    // Timer flag clear sequence
    // ****************************************
    logic [2:0] armed_q;
    // RULE_16 status then associated access
    always_ff @(posedge clk_in) begin
        if (core_reset_out) begin
            armed_q <= 3'h0;
        end else if (status_access_in) begin
            armed_q <= {capture_flag_in, match_flag_in, wrap_flag_in};
        end else begin
            armed_q <= armed_q & ~{capture_assoc_in, match_assoc_in, wrap_assoc_in};
        end
    end
    assign capture_clr_out = armed_q[2] && capture_assoc_in && !status_access_in;
    assign match_clr_out   = armed_q[1] && match_assoc_in && !status_access_in;
    assign wrap_clr_out    = armed_q[0] && wrap_assoc_in && !status_access_in;

    // ****************************************
    // Mask, external latch, low power
    // ****************************************
    logic mask_q, ext_latch_q, irq_prev_q, timer_rq, line_rq, ext_rq, any_wake;
    ric_pwr_t pwr_q;
    ric_src_t src;

    // RULE_15 enables gate requests only
    // RULE_25 timer flags gated
    assign timer_rq = timer_req(capture_flag_in, capture_int_en_in, match_flag_in,
                                match_int_en_in, wrap_flag_in, wrap_int_en_in);
    // RULE_26 shared level request
    assign line_rq  = |(flags_q & line_int_enables_in);
    // RULE_24 pin low recognised
    assign ext_rq   = ext_latch_q || !irq_s2_q;

    always_ff @(posedge clk_in) begin
        // RULE_13 latches cleared
        if (core_reset_out) begin
            ext_latch_q <= 1'b0;
            irq_prev_q  <= 1'b1;
        end else begin
            irq_prev_q <= irq_s2_q;
            // An edge seen while its own level is being taken is that same request
            if (take_int_out && src == RIC_SRC_EXT) begin
                ext_latch_q <= 1'b0;
            end else if (irq_prev_q && !irq_s2_q) begin
                ext_latch_q <= 1'b1;
            end
        end
    end

    // RULE_20 stop wake sources
    // RULE_21 wait wake sources
    assign any_wake = ext_rq || line_rq ||
                      (timer_rq && (pwr_q == RIC_WAIT || timer_ext_clk_on_in));

    always_ff @(posedge clk_in) begin
        if (core_reset_out) begin
            pwr_q <= RIC_RUN;
        end else begin
            unique case (pwr_q)
                RIC_RUN: begin
                    if (stop_in) begin
                        pwr_q <= RIC_STOP;
                    end else if (wait_in) begin
                        pwr_q <= RIC_WAIT;
                    end
                end
                RIC_WAIT, RIC_STOP: begin
                    if (any_wake) begin
                        pwr_q <= RIC_RUN;
                    end
                end
            endcase
        end
    end
    assign wait_q = (pwr_q == RIC_WAIT);

    // Stop latch survives the pin reset so the long delay can be chosen
    always_ff @(posedge clk_in) begin
        if (rst_in || por_pend_q) begin
            stop_q <= 1'b0;
        // RULE_07 stop latch cleared
        end else if (pin_rise) begin
            stop_q <= 1'b0;
        end else if (pwr_q == RIC_RUN && stop_in && !core_reset_out) begin
            stop_q <= 1'b1;
        end else if (pwr_q == RIC_STOP && any_wake) begin
            stop_q <= 1'b0;
        end
    end

    assign osc_off_out       = stop_q;
    assign core_clk_gate_out = wait_q || stop_q;

    // RULE_27 fixed priority
    // RULE_23 trap ignores mask
    // RULE_14 four sources
    always_comb begin
        src = RIC_SRC_NONE;
        if (soft_trap_in) begin
            src = RIC_SRC_TRAP;
        end else if (!mask_q && ext_rq) begin
            src = RIC_SRC_EXT;
        end else if (!mask_q && timer_rq) begin
            src = RIC_SRC_TIMER;
        end else if (!mask_q && line_rq) begin
            src = RIC_SRC_LINE;
        end
    end

    // RULE_17 boundary entry
    // RULE_22 ordinary vectors
    assign take_int_out = !core_reset_out && insn_end_in && src != RIC_SRC_NONE
                          && pwr_q == RIC_RUN;

    always_ff @(posedge clk_in) begin
        if (core_reset_out) begin
            mask_q       <= 1'b1;
            take_src_out <= RIC_SRC_NONE;
            vector_out   <= VEC_RESET;
            restore_out  <= 1'b0;
        end else begin
            restore_out <= trap_return_in;
            if (take_int_out) begin
                mask_q       <= 1'b1;
                take_src_out <= src;
                unique case (src)
                    RIC_SRC_TRAP:  vector_out <= VEC_TRAP;
                    RIC_SRC_EXT:   vector_out <= VEC_EXT;
                    RIC_SRC_TIMER: vector_out <= VEC_TIMER;
                    RIC_SRC_LINE:  vector_out <= VEC_LINE;
                    default:       vector_out <= VEC_NONE;
                endcase
            // RULE_18 restore on return
            end else if (trap_return_in || mask_clear_in || pwr_q != RIC_RUN) begin
                mask_q <= 1'b0;
            end
        end
    end
    assign global_mask_out = mask_q;

    // ****************************************
    // Checks
    // ****************************************
    vec_reset_a: assert property (@(posedge clk_in) disable iff (rst_in) // RULE_12
        core_reset_out |=> vector_out == VEC_RESET && global_mask_out)
        else $error("reset vector or mask wrong");
    trap_vec_a: assert property (@(posedge clk_in) disable iff (rst_in) // RULE_23
        take_int_out && soft_trap_in |=> vector_out == VEC_TRAP && global_mask_out)
        else $error("trap vector wrong");
    mask_block_a: assert property (@(posedge clk_in) disable iff (rst_in) // RULE_14
        take_int_out && mask_q |-> soft_trap_in)
        else $error("masked request taken");
    boundary_a: assert property (@(posedge clk_in) disable iff (rst_in) // RULE_17
        take_int_out |-> insn_end_in)
        else $error("entry off boundary");
    ext_prio_a: assert property (@(posedge clk_in) disable iff (rst_in) // RULE_27
        take_int_out && !soft_trap_in && ext_rq |=> vector_out == VEC_EXT)
        else $error("external priority wrong");
    pin_hold_a: assert property (@(posedge clk_in) disable iff (rst_in) // RULE_19
        pin_low |-> core_reset_out)
        else $error("pin low without reset");
    short_delay_a: assert property (@(posedge clk_in) disable iff (rst_in) // RULE_06
        pin_rise && !stop_q && !por_pend_q |-> core_reset_out [*2])
        else $error("short delay too short");
    line_relatch_a: assert property (@(posedge clk_in) disable iff (rst_in) // RULE_11
        !core_reset_out && line_s2_q == 4'h0 |=> line_int_flags_out == 4'hf)
        else $error("line flag not relatched");
    stop_wake_a: assert property (@(posedge clk_in) disable iff (rst_in) // RULE_20
        pwr_q == RIC_STOP && !core_reset_out && ext_rq |=> pwr_q == RIC_RUN)
        else $error("stop not woken");
endmodule

// *** rtl/ric_pkg.sv ***
package ric_pkg;
    // ****************************************
    // Timing
    // ****************************************
    localparam int unsigned CLK_HZ          = 20000000;
    localparam int unsigned LONG_START_CYC  = 4064;
    localparam int unsigned SHORT_START_CYC = 2;
    localparam int unsigned OSC_PER_BUS     = 2;
    localparam int unsigned LONG_START_OSC  = LONG_START_CYC * OSC_PER_BUS;
    localparam int unsigned CNT_W           = 12;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [15:0] TIMER_PRELOAD = 16'hfffc;
    localparam logic [1:0]  PRESCALE_ZERO = 2'h0;
    localparam logic [11:0] STACK_TOP     = 12'h0ff;

    // ****************************************
    // Vectors
    // ****************************************
    localparam logic [11:0] VEC_RESET = 12'hffe;
    localparam logic [11:0] VEC_TRAP  = 12'hffc;
    localparam logic [11:0] VEC_EXT   = 12'hffa;
    localparam logic [11:0] VEC_TIMER = 12'hff8;
    localparam logic [11:0] VEC_LINE  = 12'hff6;
    localparam logic [11:0] VEC_NONE  = 12'h000;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [2:0] {
        RIC_SRC_NONE,
        RIC_SRC_TRAP,
        RIC_SRC_EXT,
        RIC_SRC_TIMER,
        RIC_SRC_LINE
    } ric_src_t;

    typedef enum logic [1:0] {
        RIC_RUN,
        RIC_WAIT,
        RIC_STOP
    } ric_pwr_t;
endpackage

// *** rtl/ric_start_timer.sv ***
`timescale 1ns/100ps
module ric_start_timer
    import ric_pkg::*;
(
    input  wire logic             clk_in,
    input  wire logic             load_in,
    input  wire logic [CNT_W-1:0] count_in,
    output logic                  busy_out
);
    logic [CNT_W-1:0] cnt_q;

    // ****************************************
    // Down counter, busy while nonzero
    // ****************************************
    always_ff @(posedge clk_in) begin
        if (load_in) begin
            cnt_q <= count_in;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    assign busy_out = load_in || (cnt_q != '0);
endmodule

// *** testbench/ric_cpu_model.sv ***
`timescale 1ns/100ps
module ric_cpu_model
    import ric_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        core_reset_in,
    input  wire logic        clk_gate_in,
    input  wire logic        take_int_in,
    input  wire logic [11:0] vector_in,
    output logic             insn_end_out,
    output logic [11:0]      last_vec_out,
    output int               entries_out
);
    logic [1:0] phase_q;
    logic       fetch_q;

    // ****************************************
    // Instruction sequencer
    // ****************************************
    // boundary every fourth cycle
    always_ff @(posedge clk_in) begin
        if (core_reset_in || clk_gate_in) begin
            phase_q      <= 2'h0;
            insn_end_out <= 1'b0;
        end else begin
            phase_q      <= phase_q + 2'h1;
            insn_end_out <= (phase_q == 2'h2);
        end
    end

    always_ff @(posedge clk_in) begin
        if (core_reset_in) begin
            fetch_q     <= 1'b0;
            entries_out <= 0;
        end else begin
            fetch_q <= take_int_in;
            if (fetch_q) begin
                last_vec_out <= vector_in;
                entries_out  <= entries_out + 1;
            end
        end
    end
endmodule

// *** testbench/test_reset_interrupt_control.sv ***
`timescale 1ns/100ps
module test_reset_interrupt_control;
    import ric_pkg::*;
    logic        clk_in = 1'b0, rst_in = 1'b1, por_in = 1'b1, reset_pin_n_in = 1'b1;
    logic        irq_pin_n_in = 1'b1, osc_ready_in = 1'b1, soft_trap_in = 1'b0;
    logic        trap_return_in = 1'b0, stop_in = 1'b0, wait_in = 1'b0, mask_clear_in = 1'b0;
    logic        capture_flag_in = 1'b0, match_flag_in = 1'b0, wrap_flag_in = 1'b0;
    logic        wrap_int_en_in = 1'b0, status_access_in = 1'b0;
    logic        capture_assoc_in = 1'b0, match_assoc_in = 1'b0;
    logic [3:0]  line_pin_n_in = 4'hf, line_int_enables_in = 4'h0, line_flag_clr_in = 4'h0;
    logic        insn_end_in, core_reset_out, periph_reset_out, global_mask_out, take_int_out;
    logic        restore_out, osc_off_out, core_clk_gate_out, capture_clr_out, match_clr_out;
    logic [15:0] timer_preload_out;
    logic [1:0]  prescale_preload_out;
    logic [11:0] stack_preload_out, vector_out, last_vec;
    logic [3:0]  line_int_flags_out;
    int          entries, mismatches = 0, comparisons = 0;

    // ****************************************
    // Clock and instances
    // ****************************************
    initial begin
        forever #25 clk_in = ~clk_in;
    end

    ric_core u_dut (.clk_in, .rst_in, .por_in, .reset_pin_n_in, .irq_pin_n_in,
        .crystal_opt_in(1'b1), .osc_ready_in, .insn_end_in, .soft_trap_in, .trap_return_in,
        .stop_in, .wait_in, .mask_clear_in, .capture_flag_in, .match_flag_in, .wrap_flag_in,
        .capture_int_en_in(1'b0), .match_int_en_in(1'b0), .wrap_int_en_in,
        .timer_ext_clk_on_in(1'b0), .line_pin_n_in, .line_int_enables_in, .status_access_in,
        .line_flag_clr_in, .capture_assoc_in, .match_assoc_in, .wrap_assoc_in(1'b0),
        .core_reset_out, .periph_reset_out, .timer_preload_out, .prescale_preload_out,
        .stack_preload_out, .global_mask_out, .take_int_out, .take_src_out(), .vector_out,
        .restore_out, .osc_off_out, .core_clk_gate_out, .line_int_flags_out,
        .capture_clr_out, .match_clr_out, .wrap_clr_out());

    ric_cpu_model u_cpu (.clk_in, .core_reset_in(core_reset_out),
        .clk_gate_in(core_clk_gate_out), .take_int_in(take_int_out), .vector_in(vector_out),
        .insn_end_out(insn_end_in), .last_vec_out(last_vec), .entries_out(entries));

    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic report_and_stop();
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic measure(input string name, input int lo, input int hi);
        int n;
        n = 0;
        while (core_reset_out === 1'b1 && n < 5000) begin
            @(negedge clk_in);
            n++;
            if (periph_reset_out !== core_reset_out) chk("periph_reset", 16'h1, 16'h0);
        end
        comparisons++;
        if (n < lo || n > hi) begin
            mismatches++;
            $display("unexpected %s expected %0d to %0d seen %0d", name, lo, hi, n);
        end
    endtask

    task automatic serve(input logic [11:0] vec);
        int n0;
        n0 = entries;
        for (int i = 0; i < 40 && entries == n0; i++) @(negedge clk_in);
        chk("entries", 16'(n0 + 1), 16'(entries));
        chk("vector", {4'h0, vec}, {4'h0, last_vec});
        chk("mask", 16'h1, {15'h0, global_mask_out});
    endtask

    task automatic quiet(input int cyc);
        int n0;
        n0 = entries;
        repeat (cyc) @(negedge clk_in);
        chk("entries", 16'(n0), 16'(entries));
    endtask

    task automatic ret();
        @(posedge clk_in) trap_return_in <= 1'b1;
        @(posedge clk_in) trap_return_in <= 1'b0;
        @(negedge clk_in);
        chk("restore", 16'h1, {15'h0, restore_out});
    endtask

    task automatic pin_reset();
        @(posedge clk_in) reset_pin_n_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        chk("reset_vector", 16'h0ffe, {4'h0, vector_out});
        chk("reset_mask", 16'h1, {15'h0, global_mask_out});
        reset_pin_n_in <= 1'b1;
    endtask

    task automatic wake(input string name, ref logic lvl);
        for (int i = 0; i < 20 && lvl === 1'b1; i++) @(negedge clk_in);
        chk(name, 16'h0, {15'h0, lvl});
    endtask

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        #(12000 * 50);
        mismatches++;
        report_and_stop();
    end

    initial begin
        repeat (12) @(posedge clk_in);
        rst_in <= 1'b0;
        @(negedge clk_in);
        chk("timer_preload", 16'hfffc, timer_preload_out);
        chk("prescale", 16'h0, {14'h0, prescale_preload_out});
        chk("stack", 16'h00ff, {4'h0, stack_preload_out});
        chk("vector_rst", 16'h0ffe, {4'h0, vector_out});
        chk("line_flags", 16'h0, {12'h0, line_int_flags_out});
        chk("core_reset", 16'h1, {15'h0, core_reset_out});
        measure("por_delay", 4064, 4074);
        @(posedge clk_in) match_flag_in <= 1'b1;
        match_assoc_in <= 1'b1;
        capture_flag_in <= 1'b1;
        @(negedge clk_in) chk("match_clr", 16'h0, {15'h0, match_clr_out});
        @(posedge clk_in) match_assoc_in <= 1'b0;
        status_access_in <= 1'b1;
        @(posedge clk_in) status_access_in <= 1'b0;
        capture_assoc_in <= 1'b1;
        @(negedge clk_in) chk("capture_clr", 16'h1, {15'h0, capture_clr_out});
        @(posedge clk_in) capture_assoc_in <= 1'b0;
        irq_pin_n_in <= 1'b0;
        soft_trap_in <= 1'b1;
        serve(VEC_TRAP);
        @(posedge clk_in) soft_trap_in <= 1'b0;
        quiet(12);
        @(posedge clk_in) mask_clear_in <= 1'b1;
        @(posedge clk_in) mask_clear_in <= 1'b0;
        serve(VEC_EXT);
        @(posedge clk_in) irq_pin_n_in <= 1'b1;
        ret();
        @(posedge clk_in) wrap_flag_in <= 1'b1;
        line_pin_n_in <= 4'he;
        quiet(12);
        chk("line_flags", 16'h1, {12'h0, line_int_flags_out});
        @(posedge clk_in) irq_pin_n_in <= 1'b0;
        wrap_int_en_in <= 1'b1;
        line_int_enables_in <= 4'hf;
        serve(VEC_EXT);
        @(posedge clk_in) irq_pin_n_in <= 1'b1;
        ret();
        serve(VEC_TIMER);
        @(posedge clk_in) wrap_flag_in <= 1'b0;
        ret();
        serve(VEC_LINE);
        @(posedge clk_in) line_flag_clr_in <= 4'h1;
        @(posedge clk_in) line_flag_clr_in <= 4'h0;
        repeat (3) @(negedge clk_in);
        chk("line_regen", 16'h1, {12'h0, line_int_flags_out});
        @(posedge clk_in) line_pin_n_in <= 4'hf;
        repeat (3) @(posedge clk_in);
        line_flag_clr_in <= 4'hf;
        @(posedge clk_in) line_flag_clr_in <= 4'h0;
        @(negedge clk_in) chk("line_clr", 16'h0, {12'h0, line_int_flags_out});
        ret();
        @(posedge clk_in) wait_in <= 1'b1;
        @(posedge clk_in) wait_in <= 1'b0;
        @(negedge clk_in) chk("wait_gate", 16'h1, {15'h0, core_clk_gate_out});
        @(posedge clk_in) wrap_flag_in <= 1'b1;
        wake("wait_wake", core_clk_gate_out);
        serve(VEC_TIMER);
        @(posedge clk_in) wrap_flag_in <= 1'b0;
        ret();
        @(posedge clk_in) stop_in <= 1'b1;
        @(posedge clk_in) stop_in <= 1'b0;
        wrap_flag_in <= 1'b1;
        repeat (30) @(negedge clk_in);
        chk("stop_osc", 16'h1, {15'h0, osc_off_out});
        @(posedge clk_in) wrap_flag_in <= 1'b0;
        line_pin_n_in <= 4'hd;
        wake("stop_wake", osc_off_out);
        serve(VEC_LINE);
        @(posedge clk_in) line_pin_n_in <= 4'hf;
        repeat (3) @(posedge clk_in);
        line_flag_clr_in <= 4'hf;
        @(posedge clk_in) line_flag_clr_in <= 4'h0;
        ret();
        @(posedge clk_in) stop_in <= 1'b1;
        @(posedge clk_in) stop_in <= 1'b0;
        pin_reset();
        measure("stop_restart", 4064, 4074);
        chk("stop_clear", 16'h0, {15'h0, osc_off_out});
        pin_reset();
        measure("pin_restart", 2, 8);
        report_and_stop();
    end
endmodule
